// File: bench/bb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bb_host_model (
    input  wire logic clk,
    output var logic  alt_string_req = 1'b0,
    output var logic  ack_wait = 1'b0,
    output var logic  ack_rcvd = 1'b0
);
    task automatic req_string();
        @(posedge clk);
        alt_string_req <= 1'b1;
        @(posedge clk);
        alt_string_req <= 1'b0;
    endtask
    task automatic wait_ack();
        @(posedge clk);
        ack_wait <= 1'b1;
    endtask
    // Delay 0 is a prompt partner, larger values a slow one
    task automatic give_ack(input int delay);
        repeat (delay + 1) @(posedge clk);
        ack_rcvd <= 1'b1;
        ack_wait <= 1'b0;
        @(posedge clk);
        ack_rcvd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/billboard_detach_timer_b_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module billboard_detach_timer_b_asserts (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ack_wait,
    input wire logic       ack_rcvd,
    input wire logic       func_connect,
    input wire logic       func_billboard,
    input wire logic       link_comm_allow,
    input wire logic       link_timeout
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    AST_COMM_GATE: assert property (link_comm_allow == !link_timeout)
        else $error("link allowed while timed out");
    AST_FAIL_STICKY: assert property (link_timeout && !ack_rcvd |=> link_timeout)
        else $error("link timeout dropped without ack");
    AST_NO_EARLY_FAIL: assert property ($rose(ack_wait) && !link_timeout |=> (!link_timeout)[*4])
        else $error("link timeout too early");
    AST_FAIL_CAUSE: assert property ($rose(link_timeout) |-> $past(ack_wait))
        else $error("link timeout without waiting");
    AST_HOLD_DETACH: assert property ($fell(func_connect) |-> (!func_connect)[*4] ##1 func_connect)
        else $error("detach not held four cycles");
    AST_DETACH_PLAIN: assert property (!func_connect |-> !func_billboard)
        else $error("billboard shown while detached");
    AST_REATTACH_DEFAULT: assert property ($rose(func_connect) |-> !func_billboard ##1 !func_billboard)
        else $error("reattach not as default function");
    COV_DETACH: cover property ($fell(func_connect));
    COV_LINK_FAIL: cover property ($rose(link_timeout));
    COV_LINK_CLEAR: cover property ($fell(link_timeout));
endmodule
`default_nettype wire

// File: bench/billboard_detach_timer_b_tb.sv
`timescale 1ns/1ps
`default_nettype none
module billboard_detach_timer_b_tb;
    localparam int TK = 10;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, billboard_mode = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, v, w;
    logic        alt_string_req, ack_wait, ack_rcvd, func_connect, func_billboard, link_comm_allow, link_timeout;
    int          num_errors = 0, checks_done = 0, seed = 79, n, t, lim;
    always #5 clk = ~clk;
    billboard_detach_timer_b #(.TICK_CYCLES(TK), .ACK_RELAXED_CYC(20), .ACK_STRICT_CYC(6)) DUT (.clk, .rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .billboard_mode, .alt_string_req, .ack_wait,
        .ack_rcvd, .func_connect, .func_billboard, .link_comm_allow, .link_timeout);
    bb_host_model host (.clk, .alt_string_req, .ack_wait, .ack_rcvd);
    function automatic logic [7:0] desc_def(input int i);
        case (i)
            3, 4, 41: return 8'h01;
            7:        return 8'h80;
            40:       return 8'h10;
            45:       return 8'hff;
            default:  return 8'h00;
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_for(input int which, input int max);
        for (t = 0; t < max && (which ? link_timeout !== 1'b1 : func_connect !== 1'b0); t++) @(posedge clk) #1;
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(16'h413e, v); check(v, 16'h00d0);
        rd(16'h413f, v); check(v, 16'h0007);
        for (int i = 0; i < 47; i++) begin
            rd(16'h4150 + i[15:0], v); check(v, desc_def(i));
        end
        w = 8'($random(seed));
        wr(16'h4158, w); rd(16'h4158, v); check(v, w);
        wr(16'h4000, w); rd(16'h4000, v); check(v, 16'h0000);
        n = 1 + ($random(seed) & 3);
        wr(16'h413f, 8'h00); wr(16'h413e, n[7:0]); rd(16'h413e, v); check(v, 16'(n));
        @(posedge clk) billboard_mode <= 1'b1;
        repeat (20) @(posedge clk);
        #1 check(func_billboard, 1'b1);
        host.req_string();
        billboard_mode <= 1'b0;
        wait_for(0, 200);
        check(t >= (n - 1) * TK && t <= n * TK + 2, 1'b1);
        check(func_billboard, 1'b0);
        repeat (4) @(posedge clk);
        #1 check(func_connect, 1'b1);
        rd(16'h4141, v); check(v, 16'h0008);
        wr(16'h4141, 8'h08); rd(16'h4141, v); check(v, 16'h0000);
        rd(16'h4140, v); check(v, 16'h0001);
        host.wait_ack(); host.give_ack(2); #1 check(link_timeout, 1'b0);
        for (int m = 0; m < 2; m++) begin
            lim = m ? 6 : 20;
            host.wait_ack();
            wait_for(1, 100);
            check(t >= lim - 2 && t <= lim + 2, 1'b1);
            check(link_comm_allow, 1'b0);
            host.give_ack(0); #1 check(link_comm_allow, 1'b1);
            wr(16'h4140, 8'h00);
        end
        // Reset in the middle of a run must drop the timer
        wr(16'h413e, 8'h05);
        @(posedge clk) billboard_mode <= 1'b1;
        repeat (4) @(posedge clk);
        host.req_string();
        billboard_mode <= 1'b0;
        repeat (20) @(posedge clk);
        #1 check(func_billboard, 1'b1);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 check(func_billboard, 1'b0);
        check(func_connect, 1'b1);
        rd(16'h413e, v); check(v, 16'h00d0);
        rd(16'h4141, v); check(v, 16'h0000);
        end_of_test();
    end
endmodule
bind billboard_detach_timer_b billboard_detach_timer_b_asserts chk (.clk, .rst, .reg_rd, .reg_rdata, .ack_wait,
    .ack_rcvd, .func_connect, .func_billboard, .link_comm_allow, .link_timeout);
`default_nettype wire

// File: src/bb_timer_pkg.sv
package bb_timer_pkg;
    // Register offsets on the plain register port
    localparam logic [15:0] OFF_TIMEOUT_LOW   = 16'h413e;
    localparam logic [15:0] OFF_TIMEOUT_HIGH  = 16'h413f;
    localparam logic [15:0] OFF_CTRL          = 16'h4140;
    localparam logic [15:0] OFF_STATUS        = 16'h4141;
    localparam logic [15:0] OFF_DESC_BASE     = 16'h4150;
    localparam int          DESC_BYTES        = 47;
    // Descriptor byte positions inside the descriptor window
    localparam int          DESC_URL_IDX      = 3;
    localparam int          DESC_NUM_MODES    = 4;
    localparam int          DESC_VCONN_HI     = 7;
    localparam int          DESC_VERSION_LO   = 40;
    localparam int          DESC_VERSION_HI   = 41;
    localparam int          DESC_SVID_HI      = 45;
    // Reset values
    localparam logic [15:0] TIMEOUT_RESET     = 16'h07d0;
    localparam logic [7:0]  URL_IDX_RESET     = 8'h01;
    localparam logic [7:0]  NUM_MODES_RESET   = 8'h01;
    localparam logic [7:0]  VCONN_HI_RESET    = 8'h80;
    localparam logic [7:0]  VERSION_LO_RESET  = 8'h10;
    localparam logic [7:0]  VERSION_HI_RESET  = 8'h01;
    localparam logic [7:0]  SVID_HI_RESET     = 8'hff;
    // Control and status bit positions
    localparam int          CTRL_RELAXED_BIT  = 0;
    localparam int          STAT_RUN_BIT      = 0;
    localparam int          STAT_BB_BIT       = 1;
    localparam int          STAT_LINK_FAIL_BIT = 2;
    localparam int          STAT_EXPIRED_BIT  = 3;
    // Timing
    localparam int          CLK_MHZ           = 100;
    localparam int          TICK_MS           = 10;
    localparam int          TICK_CYCLES       = TICK_MS * 1000 * CLK_MHZ;
    localparam int          ACK_STRICT_US     = 3;
    localparam int          ACK_RELAXED_US    = 10;
    localparam int          ACK_STRICT_CYC    = ACK_STRICT_US * CLK_MHZ;
    localparam int          ACK_RELAXED_CYC   = ACK_RELAXED_US * CLK_MHZ;
    localparam int          DETACH_HOLD_CYC   = 4;
endpackage

// File: src/billboard_detach_timer_b.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Start detach timer when host requests the alternate-mode string.
// - On timeout, detach billboard function and re-attach as default function.
// - Timeout is 16-bit, low and high byte registers, 10 ms per step.
// - Timeout resets to 07d0h, a 20 second delay.
// - Billboard descriptor bytes are configurable with documented defaults.
// - Link acknowledgment turnaround allows 10 us instead of 3 us.
// - Exceeded turnaround budget blocks starting communication on that link.
// - On expiry force a disconnect, emulating detach, before reconnecting.
module billboard_detach_timer_b #(
    parameter int TICK_CYCLES     = bb_timer_pkg::TICK_CYCLES,
    parameter int ACK_RELAXED_CYC = bb_timer_pkg::ACK_RELAXED_CYC,
    parameter int ACK_STRICT_CYC  = bb_timer_pkg::ACK_STRICT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        billboard_mode,
    input  wire logic        alt_string_req,
    input  wire logic        ack_wait,
    input  wire logic        ack_rcvd,
    output logic             func_connect,
    output logic             func_billboard,
    output logic             link_comm_allow,
    output logic             link_timeout
);
    typedef enum logic [2:0] {ST_DEFAULT, ST_BB_IDLE, ST_BB_RUN, ST_DETACH, ST_REATTACH} state_t;

    state_t      state_r;
    logic [15:0] timeout_r;
    logic        relaxed_r;
    logic [7:0]  desc_r [bb_timer_pkg::DESC_BYTES];
    logic [31:0] tick_cnt_r;
    logic [15:0] step_cnt_r;
    logic        expired_r;
    logic [2:0]  hold_cnt_r;
    logic [31:0] ack_cnt_r;
    logic        link_fail_r;
    logic        bb_mode_meta_r;
    logic        bb_mode_sync_r;
    logic        tick;
    logic        limit_hit;
    logic [31:0] ack_limit;
    logic [15:0] desc_off;

    assign desc_off  = reg_addr - bb_timer_pkg::OFF_DESC_BASE;
    assign tick      = (state_r == ST_BB_RUN) && (tick_cnt_r == 32'(TICK_CYCLES - 1));
    assign limit_hit = tick && (step_cnt_r + 16'h0001 >= timeout_r);

    // Mode select comes from a pin; two flops before any logic reads it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bb_mode_meta_r <= 1'b0;
            bb_mode_sync_r <= 1'b0;
        end else begin
            bb_mode_meta_r <= billboard_mode;
            bb_mode_sync_r <= bb_mode_meta_r;
        end
    end

    // Registers, timeout low and high bytes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_r <= bb_timer_pkg::TIMEOUT_RESET;
            relaxed_r <= 1'b1;
        end else if (reg_wr) begin
            if (reg_addr == bb_timer_pkg::OFF_TIMEOUT_LOW)
                timeout_r[7:0] <= reg_wdata;
            if (reg_addr == bb_timer_pkg::OFF_TIMEOUT_HIGH)
                timeout_r[15:8] <= reg_wdata;
            if (reg_addr == bb_timer_pkg::OFF_CTRL)
                relaxed_r <= reg_wdata[bb_timer_pkg::CTRL_RELAXED_BIT];
        end
    end

    // Descriptor storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < bb_timer_pkg::DESC_BYTES; i++)
                desc_r[i] <= 8'h00;
            desc_r[bb_timer_pkg::DESC_URL_IDX]    <= bb_timer_pkg::URL_IDX_RESET;
            desc_r[bb_timer_pkg::DESC_NUM_MODES]  <= bb_timer_pkg::NUM_MODES_RESET;
            desc_r[bb_timer_pkg::DESC_VCONN_HI]   <= bb_timer_pkg::VCONN_HI_RESET;
            desc_r[bb_timer_pkg::DESC_VERSION_LO] <= bb_timer_pkg::VERSION_LO_RESET;
            desc_r[bb_timer_pkg::DESC_VERSION_HI] <= bb_timer_pkg::VERSION_HI_RESET;
            desc_r[bb_timer_pkg::DESC_SVID_HI]    <= bb_timer_pkg::SVID_HI_RESET;
        end else if (reg_wr && reg_addr >= bb_timer_pkg::OFF_DESC_BASE
                     && desc_off < 16'(bb_timer_pkg::DESC_BYTES)) begin
            desc_r[desc_off[5:0]] <= reg_wdata;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == bb_timer_pkg::OFF_TIMEOUT_LOW)
                reg_rdata <= timeout_r[7:0];
            else if (reg_addr == bb_timer_pkg::OFF_TIMEOUT_HIGH)
                reg_rdata <= timeout_r[15:8];
            else if (reg_addr == bb_timer_pkg::OFF_CTRL)
                reg_rdata <= {7'h00, relaxed_r};
            else if (reg_addr == bb_timer_pkg::OFF_STATUS)
                reg_rdata <= {4'h0, expired_r, link_fail_r, func_billboard, state_r == ST_BB_RUN};
            else if (reg_addr >= bb_timer_pkg::OFF_DESC_BASE && desc_off < 16'(bb_timer_pkg::DESC_BYTES))
                reg_rdata <= desc_r[desc_off[5:0]];
            else
                reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Function attach state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_DEFAULT;
        end else begin
            unique case (state_r)
                ST_DEFAULT:  if (bb_mode_sync_r) state_r <= ST_BB_IDLE;
                ST_BB_IDLE:  if (alt_string_req) state_r <= ST_BB_RUN;
                ST_BB_RUN:   if (limit_hit) state_r <= ST_DETACH;
                ST_DETACH:   if (hold_cnt_r == 3'(bb_timer_pkg::DETACH_HOLD_CYC - 1))
                                 state_r <= ST_REATTACH;
                ST_REATTACH: state_r <= ST_DEFAULT;
            endcase
        end
    end

    // Disconnect hold time
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            hold_cnt_r <= 3'h0;
        else if (state_r == ST_DETACH)
            hold_cnt_r <= hold_cnt_r + 3'h1;
        else
            hold_cnt_r <= 3'h0;
    end

    // Tick prescaler and step counter, cleared outside a run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 32'h0;
            step_cnt_r <= 16'h0;
        end else if (state_r != ST_BB_RUN) begin
            tick_cnt_r <= 32'h0;
            step_cnt_r <= 16'h0;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
            step_cnt_r <= step_cnt_r + 16'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // Sticky expiry flag; set wins, cleared by writing status with bit 3 set
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            expired_r <= 1'b0;
        else if (limit_hit)
            expired_r <= 1'b1;
        else if (reg_wr && reg_addr == bb_timer_pkg::OFF_STATUS && reg_wdata[bb_timer_pkg::STAT_EXPIRED_BIT])
            expired_r <= 1'b0;
    end

    assign func_connect   = (state_r != ST_DETACH);
    assign func_billboard = (state_r == ST_BB_IDLE) || (state_r == ST_BB_RUN);

    // Link turnaround watchdog
    assign ack_limit = relaxed_r ? 32'(ACK_RELAXED_CYC) : 32'(ACK_STRICT_CYC);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_cnt_r   <= 32'h0;
            link_fail_r <= 1'b0;
        end else if (ack_rcvd || !ack_wait) begin
            ack_cnt_r <= 32'h0;
            if (ack_rcvd)
                link_fail_r <= 1'b0;
        end else if (ack_cnt_r >= ack_limit - 32'h1) begin
            link_fail_r <= 1'b1;
        end else begin
            ack_cnt_r <= ack_cnt_r + 32'h1;
        end
    end

    assign link_comm_allow = !link_fail_r;
    assign link_timeout    = link_fail_r;
endmodule
`default_nettype wire
